// ==== inc/umcs_pkg.sv ====
// Package with register map, field positions and shared types of the modem handshake block.
// Functional notes
// R1: Loopback holds serial transmit pin marking.
// R2: Loopback feeds transmitter output into receiver.
// R3: Loopback isolates inputs, control pins go high.
// R4: Loopback keeps interrupt outputs inactive.
// R5: Writing mirrored control bits raises status interrupt.
// R6: Control bit 3 enables interrupt; mirrors status7.
// R7: Control bit 2 spare; mirrors status6.
// R8: Control bit 1 drives request-to-send low; status4.
// R9: Control bit 0 drives terminal-ready low; status5.
// R10: Status 7..4 read complemented handshake pins.
// R11: Status 3..0 sticky, cleared by status read.
// R12: Carrier change sets status bit 3.
// R13: Ring low-to-high pin edge sets bit 2.
// R14: Set-ready change sets status bit 1.
// R15: Clear-to-send change sets status bit 0.
// R16: Any change flag raises modem interrupt.
// R17: Modem interrupt reported only with enable bit 3.
// R18: Modem interrupt lowest priority, code 000.
// R19: Synchronised sampling; changes during read kept.
`default_nettype none

package umcs_pkg;

  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  // Register offsets.
  localparam logic [2:0] OFF_INT_ENABLE = 3'h0;
  localparam logic [2:0] OFF_INT_IDENT = 3'h1;
  localparam logic [2:0] OFF_CONTROL = 3'h2;
  localparam logic [2:0] OFF_STATUS = 3'h3;
  localparam logic [2:0] OFF_EVT_STATUS = 3'h4;
  localparam logic [2:0] OFF_EVT_MASK = 3'h5;

  // Control register fields.
  localparam int CTL_TERMINAL_READY = 0;
  localparam int CTL_REQUEST_SEND = 1;
  localparam int CTL_SPARE_USER = 2;
  localparam int CTL_IRQ_ENABLE = 3;
  localparam int CTL_LOOPBACK = 4;
  localparam int CTL_W = 5;

  // Interrupt enable field for modem status.
  localparam int IEN_MODEM_STATUS = 3;
  localparam int IEN_W = 4;

  // Identification values: pending modem status, and nothing pending.
  localparam logic [7:0] IDENT_MODEM = 8'h00;
  localparam logic [7:0] IDENT_NONE = 8'h01;

  // Values after reset.
  localparam logic [CTL_W-1:0] CTL_RESET = 5'h00;
  localparam logic [IEN_W-1:0] IEN_RESET = 4'h0;
  localparam logic [3:0] DELTA_RESET = 4'h0;
  localparam logic [3:0] EVT_MASK_RESET = 4'h0;
  localparam logic [7:0] RDATA_RESET = 8'h00;

  // Asserted (active high) view of the four handshake inputs.
  typedef struct packed {
    logic carrier;
    logic ring;
    logic set_ready;
    logic clear_send;
  } umcs_lines_t;

  // One register port request.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } umcs_req_t;

endpackage

`default_nettype wire

// ==== hw/umcs_top.sv ====
// Modem control and status section of a serial port, with loopback and change interrupts.
`default_nettype none

module umcs_top (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Serial data path
  input wire logic tx_shift_out,
  output logic serial_tx_pin,
  input wire logic serial_rx_pin,
  output logic rx_shift_in,
  // Handshake pins, active low
  input wire logic carrier_detect_in_n,
  input wire logic ring_in_n,
  input wire logic set_ready_in_n,
  input wire logic clear_to_send_in_n,
  output logic request_send_out_n,
  output logic terminal_ready_out_n,
  // Interrupts
  input wire logic other_irq_pending,
  output logic serial_irq_outputs,
  output logic event_irq
);

  umcs_pkg::umcs_req_t req;
  umcs_pkg::umcs_lines_t pin_meta_reg;
  umcs_pkg::umcs_lines_t pin_sync_reg;
  umcs_pkg::umcs_lines_t lines_now;
  umcs_pkg::umcs_lines_t lines_prev_reg;
  logic rx_meta_reg;
  logic rx_sync_reg;
  logic [umcs_pkg::CTL_W-1:0] control_reg;
  logic [umcs_pkg::IEN_W-1:0] int_enable_reg;
  logic [3:0] delta_reg;
  logic [3:0] delta_set;
  logic [3:0] delta_next;
  logic [3:0] evt_status_reg;
  logic [3:0] evt_status_next;
  logic [3:0] evt_mask_reg;
  logic [7:0] status_value;
  logic [7:0] ident_value;
  logic [7:0] read_value;
  logic [7:0] rdata_reg;
  logic loopback;
  logic modem_int;
  logic status_read;
  logic evt_read;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign loopback = control_reg[umcs_pkg::CTL_LOOPBACK];
  assign status_read = req.rd && (req.addr == umcs_pkg::OFF_STATUS);
  assign evt_read = req.rd && (req.addr == umcs_pkg::OFF_EVT_STATUS);

  // R19: two-flop synchronisers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pin_meta_reg <= 4'hf;
      pin_sync_reg <= 4'hf;
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
    end else begin
      pin_meta_reg <= '{carrier: carrier_detect_in_n, ring: ring_in_n,
                        set_ready: set_ready_in_n, clear_send: clear_to_send_in_n};
      pin_sync_reg <= pin_meta_reg;
      rx_meta_reg <= serial_rx_pin;
      rx_sync_reg <= rx_meta_reg;
    end
  end

  // Register writes. Reserved bits are simply not stored.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      control_reg <= umcs_pkg::CTL_RESET;
      int_enable_reg <= umcs_pkg::IEN_RESET;
      evt_mask_reg <= umcs_pkg::EVT_MASK_RESET;
    end else if (req.wr) begin
      case (req.addr)
        umcs_pkg::OFF_CONTROL: control_reg <= req.wdata[umcs_pkg::CTL_W-1:0];
        umcs_pkg::OFF_INT_ENABLE: int_enable_reg <= req.wdata[umcs_pkg::IEN_W-1:0];
        umcs_pkg::OFF_EVT_MASK: evt_mask_reg <= req.wdata[3:0];
        default: ;
      endcase
    end
  end

  // R3: in loopback the pins are ignored and the control bits stand in.
  always_comb begin
    if (loopback) begin
      // R6: irq enable mirrors carrier
      lines_now.carrier = control_reg[umcs_pkg::CTL_IRQ_ENABLE];
      // R7: spare bit mirrors ring
      lines_now.ring = control_reg[umcs_pkg::CTL_SPARE_USER];
      // R9: terminal ready mirrors set-ready
      lines_now.set_ready = control_reg[umcs_pkg::CTL_TERMINAL_READY];
      // R8: request-to-send mirrors clear-to-send
      lines_now.clear_send = control_reg[umcs_pkg::CTL_REQUEST_SEND];
    end else begin
      // R10: complemented pin levels
      lines_now = ~pin_sync_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      lines_prev_reg <= 4'h0;
    end else begin
      lines_prev_reg <= lines_now;
    end
  end

  // R5: a mirrored bit written to 1 shows as a change and so as an interrupt; the ring bit flags only when written back to 0.
  always_comb begin
    // R12: carrier change either way
    delta_set[3] = lines_now.carrier ^ lines_prev_reg.carrier;
    // R13: ring pin low-to-high means the asserted view falls
    delta_set[2] = lines_prev_reg.ring & ~lines_now.ring;
    // R14: set-ready change
    delta_set[1] = lines_now.set_ready ^ lines_prev_reg.set_ready;
    // R15: clear-to-send change
    delta_set[0] = lines_now.clear_send ^ lines_prev_reg.clear_send;
  end

  // R11: sticky flags cleared by reading; R19: a change in the read cycle wins.
  assign delta_next = (delta_reg & ~{4{status_read}}) | delta_set;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      delta_reg <= umcs_pkg::DELTA_RESET;
    end else begin
      delta_reg <= delta_next;
    end
  end

  // Event status: each new change flag is latched until this register is read.
  assign evt_status_next = (evt_status_reg & ~{4{evt_read}}) | delta_set;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      evt_status_reg <= 4'h0;
    end else begin
      evt_status_reg <= evt_status_next;
    end
  end

  assign status_value = {lines_now.carrier, lines_now.ring, lines_now.set_ready,
                         lines_now.clear_send, delta_reg};

  // R16: any change flag gives the condition; R17: only when enabled.
  assign modem_int = (|delta_reg) && int_enable_reg[umcs_pkg::IEN_MODEM_STATUS];

  // R18: lowest priority, so only shown when no other source is pending.
  assign ident_value = (modem_int && !other_irq_pending) ? umcs_pkg::IDENT_MODEM
                                                        : umcs_pkg::IDENT_NONE;

  always_comb begin
    case (req.addr)
      umcs_pkg::OFF_INT_ENABLE: read_value = {4'h0, int_enable_reg};
      umcs_pkg::OFF_INT_IDENT: read_value = ident_value;
      umcs_pkg::OFF_CONTROL: read_value = {3'h0, control_reg};
      umcs_pkg::OFF_STATUS: read_value = status_value;
      umcs_pkg::OFF_EVT_STATUS: read_value = {4'h0, evt_status_reg};
      umcs_pkg::OFF_EVT_MASK: read_value = {4'h0, evt_mask_reg};
      default: read_value = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the strobe, zero otherwise.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rdata_reg <= umcs_pkg::RDATA_RESET;
    end else if (req.rd) begin
      rdata_reg <= read_value;
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  assign reg_rdata = rdata_reg;

  // Pin and path outputs are registered so they never glitch at the boundary.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      serial_tx_pin <= 1'b1;
      rx_shift_in <= 1'b1;
      request_send_out_n <= 1'b1;
      terminal_ready_out_n <= 1'b1;
    end else begin
      // R1: marking level in loopback
      serial_tx_pin <= loopback | tx_shift_out;
      // R2: receiver fed from transmitter
      rx_shift_in <= loopback ? tx_shift_out : rx_sync_reg;
      // R3: control pins forced inactive; R8: active-low drive
      request_send_out_n <= loopback | ~control_reg[umcs_pkg::CTL_REQUEST_SEND];
      // R3: control pins forced inactive; R9: active-low drive
      terminal_ready_out_n <= loopback | ~control_reg[umcs_pkg::CTL_TERMINAL_READY];
    end
  end

  // Interrupt outputs: serial one gated by the enable bit, event one by the event mask; both silenced in loopback.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      serial_irq_outputs <= 1'b0;
      event_irq <= 1'b0;
    end else begin
      // R4: inactive in loopback; R6: output enable
      serial_irq_outputs <= !loopback && control_reg[umcs_pkg::CTL_IRQ_ENABLE]
                            && (modem_int || other_irq_pending);
      // R4: inactive in loopback
      event_irq <= !loopback && (|(evt_status_reg & evt_mask_reg));
    end
  end

endmodule

`default_nettype wire

// ==== tb/umcs_chk.sv ====
// Concurrent checks on the ports of the modem handshake block.
`default_nettype none
module umcs_chk (
  // Clock, reset and register port
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Pins and interrupts
  input wire logic tx_shift_out,
  input wire logic serial_tx_pin,
  input wire logic serial_rx_pin,
  input wire logic rx_shift_in,
  input wire logic carrier_detect_in_n,
  input wire logic ring_in_n,
  input wire logic set_ready_in_n,
  input wire logic clear_to_send_in_n,
  input wire logic request_send_out_n,
  input wire logic terminal_ready_out_n,
  input wire logic serial_irq_outputs,
  input wire logic event_irq
);
  logic [4:0] ctl_reg;
  logic [2:0] rst_hist_reg;
  wire logic [3:0] pins = {carrier_detect_in_n, ring_in_n, set_ready_in_n, clear_to_send_in_n};
  // Past values reach back three cycles, so checks rest until reset has left that window.
  always_ff @(posedge clk_sys) begin
    rst_hist_reg <= {rst_hist_reg[1:0], reset};
    if (reset) ctl_reg <= 5'h00;
    else if (reg_wr && reg_addr == umcs_pkg::OFF_CONTROL) ctl_reg <= reg_wdata[4:0];
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset || |rst_hist_reg);
  chk_tx_marking: assert property (
    serial_tx_pin == ($past(ctl_reg[4]) | $past(tx_shift_out))) else $error("tx pin wrong");
  chk_rx_route: assert property (
    rx_shift_in == ($past(ctl_reg[4]) ? $past(tx_shift_out) : $past(serial_rx_pin, 3)))
    else $error("rx route wrong");
  chk_rts_drive: assert property (
    request_send_out_n == ($past(ctl_reg[4]) | ~$past(ctl_reg[1]))) else $error("rts wrong");
  chk_dtr_drive: assert property (
    terminal_ready_out_n == ($past(ctl_reg[4]) | ~$past(ctl_reg[0]))) else $error("dtr wrong");
  chk_irq_gate: assert property (
    serial_irq_outputs |-> $past(ctl_reg[3]) && !$past(ctl_reg[4])) else $error("irq ungated");
  chk_event_quiet: assert property (
    ctl_reg[4] |=> !event_irq) else $error("event irq in loopback");
  chk_loop_mirror: assert property (
    reg_rd && reg_addr == umcs_pkg::OFF_STATUS && ctl_reg[4] |=> reg_rdata[7:4] ==
    {$past(ctl_reg[3]), $past(ctl_reg[2]), $past(ctl_reg[0]), $past(ctl_reg[1])})
    else $error("mirror wrong");
  chk_line_view: assert property (
    reg_rd && reg_addr == umcs_pkg::OFF_STATUS && !ctl_reg[4] && $stable(pins) &&
    pins == $past(pins, 2) && pins == $past(pins, 3) |=> reg_rdata[7:4] == ~$past(pins))
    else $error("line view wrong");
endmodule
bind umcs_top umcs_chk umcs_chk_i (.clk_sys, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .tx_shift_out, .serial_tx_pin, .serial_rx_pin, .rx_shift_in, .carrier_detect_in_n,
  .ring_in_n, .set_ready_in_n, .clear_to_send_in_n, .request_send_out_n, .terminal_ready_out_n,
  .serial_irq_outputs, .event_irq);
`default_nettype wire

// ==== tb/umcs_modem.sv ====
// Modem model: echoes the terminal's handshake outputs, carrier and ring on command.
`default_nettype none
module umcs_modem (
  // Clock and terminal side
  input wire logic clk_sys,
  input wire logic request_send_out_n,
  input wire logic terminal_ready_out_n,
  // Test controls
  input wire logic carrier_on,
  input wire logic ring_on,
  input wire logic slow,
  // Modem lines, active low
  output logic carrier_detect_in_n,
  output logic ring_in_n,
  output logic set_ready_in_n,
  output logic clear_to_send_in_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] echo_reg;
  initial begin
    echo_reg = 16'h0000;
    {carrier_detect_in_n, ring_in_n, set_ready_in_n, clear_to_send_in_n} = 4'hf;
  end
  // A slow modem answers eight cycles late, as a real data set may.
  always @(posedge clk_sys) begin
    echo_reg <= {echo_reg[13:0], ~request_send_out_n, ~terminal_ready_out_n};
    carrier_detect_in_n <= ~carrier_on;
    ring_in_n <= ~ring_on;
    {clear_to_send_in_n, set_ready_in_n} <= ~(slow ? echo_reg[15:14] : echo_reg[1:0]);
  end
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench of the modem handshake block.
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, reset, reg_wr, reg_rd, tx_shift_out, serial_rx_pin, other_irq_pending;
  logic serial_tx_pin, rx_shift_in, rts_n, dtr_n, cd_n, ri_n, dsr_n, cts_n, irq, ev_irq;
  logic carrier_on, ring_on, slow;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rdv;
  int err_count, num_checks, cycles;
  umcs_top umcs_top_i (.clk_sys, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .tx_shift_out, .serial_tx_pin, .serial_rx_pin, .rx_shift_in, .carrier_detect_in_n(cd_n),
    .ring_in_n(ri_n), .set_ready_in_n(dsr_n), .clear_to_send_in_n(cts_n),
    .request_send_out_n(rts_n), .terminal_ready_out_n(dtr_n), .other_irq_pending,
    .serial_irq_outputs(irq), .event_irq(ev_irq));
  umcs_modem umcs_modem_i (.clk_sys, .request_send_out_n(rts_n), .terminal_ready_out_n(dtr_n),
    .carrier_on, .ring_on, .slow, .carrier_detect_in_n(cd_n), .ring_in_n(ri_n),
    .set_ready_in_n(dsr_n), .clear_to_send_in_n(cts_n));
  task automatic w(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    {reg_wr, reg_addr, reg_wdata} <= {1'h1, a, d};
    @(posedge clk_sys);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge clk_sys);
    {reg_rd, reg_addr} <= {1'h1, a};
    @(posedge clk_sys);
    reg_rd <= 1'h0;
    @(negedge clk_sys);
    rdv = reg_rdata;
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic s_lines();
    rd(3);
    `CHK(rdv, 8'h00)
    `CHK({rts_n, dtr_n, serial_tx_pin}, 3'h7)
    wr(2, 8'h03);
    w(2);
    `CHK({rts_n, dtr_n}, 2'h0)
    w(8);
    rd(3);
    `CHK(rdv, 8'h33)
    rd(3);
    `CHK(rdv, 8'h30)
    @(posedge clk_sys) slow <= 1'h1;
    wr(2, 8'h00);
    w(16);
    rd(3);
    `CHK(rdv, 8'h03)
    @(posedge clk_sys) carrier_on <= 1'h1;
    w(8);
    rd(3);
    `CHK(rdv, 8'h88)
    @(posedge clk_sys) ring_on <= 1'h1;
    w(8);
    rd(3);
    `CHK(rdv, 8'hc0)
    @(posedge clk_sys) ring_on <= 1'h0;
    w(8);
    rd(3);
    `CHK(rdv, 8'h84)
  endtask
  task automatic s_irq();
    wr(5, 8'h08);
    wr(2, 8'h08);
    @(posedge clk_sys) carrier_on <= 1'h0;
    w(8);
    `CHK({irq, ev_irq}, 2'h1)
    rd(1);
    `CHK(rdv, 8'h01)
    wr(0, 8'h08);
    w(2);
    `CHK(irq, 1'h1)
    rd(1);
    `CHK(rdv, 8'h00)
    rd(4);
    `CHK(rdv, 8'h0f)
    rd(3);
    `CHK(rdv, 8'h08)
    w(2);
    `CHK({irq, ev_irq}, 2'h0)
    @(posedge clk_sys) other_irq_pending <= 1'h1;
    w(2);
    `CHK(irq, 1'h1)
  endtask
  task automatic s_loop();
    logic [15:0] steps [4] = '{16'h1122, 16'h1331, 16'h1770, 16'h1ff8};
    wr(2, 8'h1f);
    w(3);
    `CHK({serial_tx_pin, rts_n, dtr_n, irq, ev_irq}, 5'h1c)
    @(posedge clk_sys) tx_shift_out <= 1'h1;
    w(2);
    `CHK(rx_shift_in, 1'h1)
    rd(3);
    rd(3);
    `CHK(rdv, 8'hf0)
    wr(2, 8'h10);
    w(2);
    rd(3);
    foreach (steps[i]) begin
      wr(2, steps[i][15:8]);
      w(2);
      rd(3);
      `CHK(rdv, steps[i][7:0])
    end
    wr(2, 8'h00);
    @(posedge clk_sys) {serial_rx_pin, tx_shift_out} <= 2'h0;
    w(5);
    `CHK({rx_shift_in, serial_tx_pin}, 2'h0)
    wr(7, 8'hff);
    rd(7);
    `CHK(rdv, 8'h00)
  endtask
  initial begin
    clk_sys = 1'h0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      give_verdict();
    end
  end
  initial begin
    {reset, reg_wr, reg_rd, other_irq_pending, carrier_on, ring_on, slow} = 7'h40;
    {tx_shift_out, serial_rx_pin, reg_addr, reg_wdata} = 13'h1800;
    repeat (12) @(posedge clk_sys);
    reset <= 1'h0;
    w(4);
    s_lines();
    s_irq();
    s_loop();
    give_verdict();
  end
endmodule
`default_nettype wire
